// ==== shared/cgms_pkg.sv ====
// Constants and carrier types for the clock generator mode sequencer.
// Assumes one 50 MHz core clock and board pins sampled through synchronisers.
// What this block does
// RQ1: After PLL stable, apply preloaded levels, run
// RQ2: Strap change: bank static briefly, then resumes
// RQ3: System should change frequency only, not type
// RQ4: Data low, powerdown pin high: full power-down
// RQ5: Powerdown pin low again restarts whole sequence
// RQ6: Register file can also request power-down
// RQ7: Banks 1-3 low/high select frequency table
// RQ8: Banks 1-3 mid or floating is default
// RQ9: Bank 4 first low: single-ended choices
// RQ10: Bank 4 first mid/high: differential choices
// RQ11: Bus mode needs data line high at power-up
// RQ12: Bus mode preloads straps, holds outputs static
// RQ13: Bus mode ignores later select pin changes
// RQ14: Mixed control low keeps all banks static
// RQ15: Mixed high, first low: only bank 4 runs
// RQ16: Mixed high, first mid/high: banks 1-3 run
// RQ17: Banks 1-3 mixed case ignores further pins
// RQ18: Mixed low: bus address from bank-4 pins
// RQ19: Register load releases held banks, follows registers
// RQ20: Unprogrammed bank takes its strap configuration
// RQ21: Power cycle clears registers, restarts sequence
// RQ22: Registers steer enable, frequency, type, power, bypass
// RQ23: Static differential: true low, complement high
// RQ24: Data line high leaves strap mode permanently
// RQ25: Disabled bank levels depend on output type
// RQ26: Three-level pins resolve to low, mid, high
// RQ27: Gating static until PLL stable each start
package cgms_pkg;

  // Sizes and indices
  localparam int NUM_BANKS     = 4;
  localparam int NUM_SEL       = 5;
  localparam int BANK4_IDX     = 3;
  localparam int SEL_FIRST     = 3;
  localparam int SEL_SECOND    = 4;
  localparam int HOLD_W        = 4;
  localparam int SETTLE_W      = 2;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int HOLD_NS       = 160;
  localparam int HOLD_CYCLES   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES   = 2;

  // Resolved three-level pin value
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } cgms_lvl_e;

  // Output frequency codes
  typedef enum logic [3:0] {
    FREQ_25   = 4'h0,
    FREQ_33   = 4'h1,
    FREQ_50   = 4'h2,
    FREQ_66   = 4'h3,
    FREQ_100  = 4'h4,
    FREQ_125  = 4'h5,
    FREQ_133  = 4'h6,
    FREQ_156  = 4'h7,
    FREQ_161  = 4'h8
  } cgms_freq_e;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_PRELOAD   = 4'h1,
    ST_WAIT_PLL  = 4'h2,
    ST_RUN       = 4'h4,
    ST_POWERDOWN = 4'h8
  } cgms_state_e;

  // Bank configuration: level type, divider type, frequency
  typedef struct packed {
    logic       diff;
    logic       frac;
    cgms_freq_e freq;
  } cgms_cfg_s;

  localparam cgms_cfg_s CFG_RESET = '{diff: 1'b1, frac: 1'b0, freq: FREQ_156};

  // Board pins; select pins are {above_upper, above_lower} comparator pairs
  typedef struct packed {
    logic [1:0] bank1_freq_select;
    logic [1:0] bank2_freq_select;
    logic [1:0] bank3_freq_select;
    logic [1:0] bank4_select_first;
    logic [1:0] bank4_select_second;
    logic       data_line;
    logic       bus_clock_powerdown_pin;
    logic       mixed_control;
  } cgms_pins_s;

  // Register file contents delivered by the two-wire bus controller
  typedef struct packed {
    logic [NUM_BANKS-1:0]            programmed;
    logic [NUM_BANKS-1:0]            output_enable;
    logic [NUM_BANKS-1:0]            block_powerdown;
    logic                            ref_bypass;
    logic                            powerdown;
    cgms_cfg_s [NUM_BANKS-1:0]       bank_cfg;
  } cgms_regfile_s;

  localparam cgms_regfile_s REGFILE_RESET = '0;

  // Per-bank output towards dividers and output drivers
  typedef struct packed {
    logic      run;
    logic      bank_true_output;
    logic      bank_complement_output;
    cgms_cfg_s cfg;
  } cgms_bank_s;

endpackage

// ==== hw/cgms_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/1ps
module cgms_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import cgms_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cgms_sync_s;

  cgms_sync_s s_q;
  cgms_sync_s s_d;

  // Shift one stage per clock
  always_comb
  begin
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;
endmodule

// ==== hw/cgms_sequencer.sv ====
// Mode and output-selection sequencer for a four-bank clock generator.
// Assumes the PLL, dividers and drivers sit outside and obey BANK_OUT;
// the bus controller hands over whole register files on REG_LOAD.
`timescale 1ns/1ps
module cgms_sequencer #(
  parameter int STATIC_HOLD_CYCLES = cgms_pkg::HOLD_CYCLES
) (
  input  wire logic                                     CORE_CLK,
  input  wire logic                                     RST,
  input  wire cgms_pkg::cgms_pins_s                     PIN_IN,
  input  wire logic                                     PLL_STABLE,
  input  wire logic                                     REG_LOAD,
  input  wire cgms_pkg::cgms_regfile_s                  REG_FILE,
  output cgms_pkg::cgms_bank_s [cgms_pkg::NUM_BANKS-1:0] BANK_OUT,
  output logic                                          POWER_DOWN,
  output logic [cgms_pkg::NUM_BANKS-1:0]                BLOCK_POWERDOWN,
  output logic                                          REF_BYPASS,
  output logic                                          BUS_MODE,
  output logic [3:0]                                    BUS_ADDR_SEL
);
  import cgms_pkg::*;

  typedef logic [HOLD_W-1:0] cgms_hold_t;

  // Whole sequencer state
  typedef struct packed {
    cgms_state_e                        state;
    logic [SETTLE_W-1:0]                settle;
    logic                               bus_mode;
    logic                               strap_left;
    logic                               mixed_ctl;
    logic                               loaded;
    logic                               reg_pd;
    logic                               pd;
    logic [3:0]                         addr;
    cgms_regfile_s                      regs;
    cgms_cfg_s [NUM_BANKS-1:0]          pre;
    cgms_bank_s [NUM_BANKS-1:0]         bank;
    cgms_hold_t [NUM_BANKS-1:0]         hold;
  } cgms_st_s;

  localparam cgms_hold_t HOLD_LOAD = HOLD_W'(STATIC_HOLD_CYCLES);
  localparam cgms_hold_t HOLD_LAST = HOLD_W'(1);
  localparam logic [SETTLE_W-1:0] SETTLE_DONE = SETTLE_W'(SYNC_STAGES);

  cgms_st_s   s_q;
  cgms_st_s   s_d;
  cgms_pins_s sp;
  logic       pll_ok;

  logic      [NUM_SEL-1:0][1:0]  sel_raw;
  cgms_lvl_e [NUM_SEL-1:0]       sel_lvl;
  cgms_cfg_s [NUM_BANKS-1:0]     strap_cfg;

  // Pins and PLL flag cross into the core clock
  cgms_sync #(
    .WIDTH ($bits(cgms_pins_s) + 1)
  ) u_sync (
    .clk (CORE_CLK),
    .rst (RST),
    .d   ({PIN_IN, PLL_STABLE}),
    .q   ({sp, pll_ok})
  );

  // Comparator pair to three-level code, float sits mid
  function automatic cgms_lvl_e resolve_lvl(input logic [1:0] raw);
    cgms_lvl_e r;
    if (raw[1])
      r = LVL_HIGH;
    else if (!raw[0])
      r = LVL_LOW;
    else
      r = LVL_MID;
    return r;
  endfunction

  function automatic cgms_cfg_s mk_cfg(input logic diff, input logic frac, input cgms_freq_e freq);
    cgms_cfg_s c;
    c.diff = diff;
    c.frac = frac;
    c.freq = freq;
    return c;
  endfunction

  // Banks 1 to 3 table, all differential integer
  function automatic cgms_cfg_s decode_low_bank(input int idx, input cgms_lvl_e lvl);
    cgms_cfg_s c;
    c = CFG_RESET;
    case (lvl)
      LVL_LOW:  c = mk_cfg(1'b1, 1'b0, FREQ_156);                  // RQ7
      LVL_HIGH:                                                    // RQ7
      begin
        if (idx == 1)
          c = mk_cfg(1'b1, 1'b0, FREQ_125);
        else
          c = mk_cfg(1'b1, 1'b0, FREQ_50);
      end
      default:                                                     // RQ8
      begin
        if (idx == 0)
          c = mk_cfg(1'b1, 1'b0, FREQ_25);
        else if (idx == 1)
          c = mk_cfg(1'b1, 1'b0, FREQ_100);
        else
          c = mk_cfg(1'b1, 1'b0, FREQ_125);
      end
    endcase
    return c;
  endfunction

  // Bank 4 table from both select pins
  function automatic cgms_cfg_s decode_bank4(input cgms_lvl_e a, input cgms_lvl_e b);
    cgms_cfg_s c;
    c = CFG_RESET;
    case (a)
      LVL_LOW:                                                     // RQ9
      begin
        if (b == LVL_LOW)
          c = mk_cfg(1'b0, 1'b0, FREQ_33);
        else if (b == LVL_HIGH)
          c = mk_cfg(1'b0, 1'b1, FREQ_133);
        else
          c = mk_cfg(1'b0, 1'b1, FREQ_66);
      end
      LVL_HIGH:                                                    // RQ10
      begin
        if (b == LVL_LOW)
          c = mk_cfg(1'b1, 1'b0, FREQ_25);
        else if (b == LVL_HIGH)
          c = mk_cfg(1'b1, 1'b1, FREQ_161);
        else
          c = mk_cfg(1'b1, 1'b0, FREQ_100);
      end
      default:                                                     // RQ10
      begin
        if (b == LVL_LOW)
          c = mk_cfg(1'b1, 1'b1, FREQ_133);
        else if (b == LVL_HIGH)
          c = mk_cfg(1'b1, 1'b0, FREQ_125);
        else
          c = mk_cfg(1'b1, 1'b0, FREQ_156);
      end
    endcase
    return c;
  endfunction

  // Select pins gathered in bank order
  assign sel_raw[0]          = sp.bank1_freq_select;
  assign sel_raw[1]          = sp.bank2_freq_select;
  assign sel_raw[2]          = sp.bank3_freq_select;
  assign sel_raw[SEL_FIRST]  = sp.bank4_select_first;
  assign sel_raw[SEL_SECOND] = sp.bank4_select_second;

  // Three-level resolution of every select pin
  for (genvar g = 0; g < NUM_SEL; g++)
  begin : g_lvl
    assign sel_lvl[g] = resolve_lvl(sel_raw[g]);                   // RQ26
  end

  // Strap configuration currently on the pins
  for (genvar g = 0; g < BANK4_IDX; g++)
  begin : g_low_cfg
    assign strap_cfg[g] = decode_low_bank(g, sel_lvl[g]);
  end
  assign strap_cfg[BANK4_IDX] = decode_bank4(sel_lvl[SEL_FIRST], sel_lvl[SEL_SECOND]);

  // Sequencer next state
  always_comb
  begin
    s_d = s_q;
    case (s_q.state)
      ST_PRELOAD:
      begin
        // Let synchronisers fill, then latch straps and mode
        if (s_q.settle != SETTLE_DONE)
        begin
          s_d.settle = s_q.settle + SETTLE_W'(1);
        end
        else
        begin
          s_d.bus_mode   = sp.data_line;                           // RQ11
          s_d.strap_left = 1'b0;
          s_d.loaded     = 1'b0;                                   // RQ21
          s_d.reg_pd     = 1'b0;
          s_d.regs       = REGFILE_RESET;                          // RQ21
          s_d.pre        = strap_cfg;                              // RQ12
          s_d.addr       = {sel_lvl[SEL_FIRST], sel_lvl[SEL_SECOND]}; // RQ18
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            s_d.bank[i].cfg = strap_cfg[i];
            s_d.bank[i].run = 1'b0;
            s_d.hold[i]     = '0;
          end
          s_d.state = ST_WAIT_PLL;
        end
      end
      ST_WAIT_PLL:
      begin
        // Outputs stay gated until the PLL reports stable
        if (pll_ok)                                                // RQ27
        begin
          s_d.mixed_ctl = sp.mixed_control;
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            if (s_q.loaded)
              s_d.bank[i].run = s_q.regs.output_enable[i] & ~s_q.regs.block_powerdown[i];
            else if (!s_q.bus_mode || s_q.strap_left)
              s_d.bank[i].run = 1'b1;                              // RQ1
            else if (!sp.mixed_control)
              s_d.bank[i].run = 1'b0;                              // RQ14
            else if (sel_lvl[SEL_FIRST] == LVL_LOW)
              s_d.bank[i].run = (i == BANK4_IDX);                  // RQ15
            else
              s_d.bank[i].run = (i != BANK4_IDX);                  // RQ16
          end
          s_d.state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!s_q.bus_mode)
        begin
          // Strap mode follows pins with a static gap per change
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            if (strap_cfg[i] != s_q.bank[i].cfg)
            begin
              s_d.bank[i].cfg = strap_cfg[i];                      // RQ2
              s_d.bank[i].run = 1'b0;
              s_d.hold[i]     = HOLD_LOAD;
            end
            else if (s_q.hold[i] != '0)
            begin
              s_d.hold[i] = s_q.hold[i] - HOLD_LAST;
              if (s_q.hold[i] == HOLD_LAST)
                s_d.bank[i].run = 1'b1;                            // RQ2
            end
          end
        end
        else if (REG_LOAD)                                         // RQ13 RQ17
        begin
          // Pins frozen; only register files change the banks
          s_d.regs   = REG_FILE;                                   // RQ22
          s_d.loaded = 1'b1;
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            s_d.hold[i]     = '0;
            s_d.bank[i].cfg = REG_FILE.programmed[i] ? REG_FILE.bank_cfg[i] : s_q.pre[i]; // RQ20
            s_d.bank[i].run = REG_FILE.output_enable[i] & ~REG_FILE.block_powerdown[i]; // RQ19
          end
          if (REG_FILE.powerdown)
          begin
            s_d.reg_pd = 1'b1;                                     // RQ6
            s_d.state  = ST_POWERDOWN;
          end
        end
      end
      ST_POWERDOWN:
      begin
        // Pin release restarts from scratch; register release keeps registers
        if (!s_q.bus_mode && !sp.bus_clock_powerdown_pin)
        begin
          s_d.settle = '0;                                         // RQ5
          s_d.state  = ST_PRELOAD;
        end
        else if (s_q.reg_pd && REG_LOAD && !REG_FILE.powerdown)
        begin
          s_d.regs   = REG_FILE;
          s_d.reg_pd = 1'b0;
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            s_d.bank[i].cfg = REG_FILE.programmed[i] ? REG_FILE.bank_cfg[i] : s_q.pre[i]; // RQ20
          end
          s_d.state = ST_WAIT_PLL;
        end
      end
      default:
      begin
        s_d.state = ST_PRELOAD;
      end
    endcase

    // Data line high in strap mode: bus mode until power cycle
    if (!s_q.bus_mode && s_q.state != ST_PRELOAD && sp.data_line)
    begin
      s_d.bus_mode   = 1'b1;                                       // RQ24
      s_d.strap_left = 1'b1;
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        s_d.hold[i] = '0;
      end
    end

    // Pin power-down wins from any state in strap mode while data line low
    if (!s_q.bus_mode && !sp.data_line && sp.bus_clock_powerdown_pin)
    begin
      s_d.state = ST_POWERDOWN;                                    // RQ4
    end

    // Everything gated off while powered down or not yet running
    if (s_d.state != ST_RUN)
    begin
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        s_d.bank[i].run = 1'b0;                                    // RQ27
      end
    end

    // Static levels for banks that are not running
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      s_d.bank[i].bank_true_output = 1'b0;
      if (s_d.state == ST_POWERDOWN || s_d.bank[i].run)
        s_d.bank[i].bank_complement_output = 1'b0;
      else if (s_d.state == ST_RUN && s_d.loaded &&
               (!s_d.regs.output_enable[i] || s_d.regs.block_powerdown[i]))
        s_d.bank[i].bank_complement_output = s_d.bank[i].cfg.diff; // RQ25
      else
        s_d.bank[i].bank_complement_output = 1'b1;                 // RQ23
    end

    // Power-down flag registered alongside the state
    s_d.pd = (s_d.state == ST_POWERDOWN);                          // RQ4
  end

  // State register
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q          <= '0;
      s_q.state    <= ST_PRELOAD;
      s_q.regs     <= REGFILE_RESET;
      s_q.pre      <= {NUM_BANKS{CFG_RESET}};
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        s_q.bank[i].cfg                    <= CFG_RESET;
        s_q.bank[i].bank_complement_output <= 1'b1;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign BANK_OUT        = s_q.bank;
  assign POWER_DOWN      = s_q.pd;
  assign BLOCK_POWERDOWN = s_q.regs.block_powerdown;
  assign REF_BYPASS      = s_q.regs.ref_bypass;
  assign BUS_MODE        = s_q.bus_mode;
  assign BUS_ADDR_SEL    = s_q.addr;
endmodule

// ==== verif/cgms_sequencer_props.sv ====
// Port-level checker for the mode sequencer.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module cgms_sequencer_props #(
  parameter int STATIC_HOLD_CYCLES = cgms_pkg::HOLD_CYCLES
) (
  input wire logic                                     CORE_CLK,
  input wire logic                                     RST,
  input wire cgms_pkg::cgms_pins_s                     PIN_IN,
  input wire logic                                     PLL_STABLE,
  input wire logic                                     REG_LOAD,
  input wire cgms_pkg::cgms_regfile_s                  REG_FILE,
  input wire cgms_pkg::cgms_bank_s [cgms_pkg::NUM_BANKS-1:0] BANK_OUT,
  input wire logic                                     POWER_DOWN,
  input wire logic [cgms_pkg::NUM_BANKS-1:0]           BLOCK_POWERDOWN,
  input wire logic                                     REF_BYPASS,
  input wire logic                                     BUS_MODE,
  input wire logic [3:0]                               BUS_ADDR_SEL
);
  import cgms_pkg::*;
  logic [3:0] run_v;
  logic [3:0] true_v;
  logic [3:0] comp_v;
  logic [7:0] low_q;
  logic       loaded_q;
  logic       ran_q;
  // Per-bank vectors
  always_comb
  begin
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      run_v[b] = BANK_OUT[b].run;
      true_v[b] = BANK_OUT[b].bank_true_output;
      comp_v[b] = BANK_OUT[b].bank_complement_output;
    end
  end
  // Bank 4 idle count, load and strap-run history
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      low_q <= 8'h00;
      loaded_q <= 1'b0;
      ran_q <= 1'b0;
    end
    else
    begin
      low_q <= run_v[3] ? 8'h00 : (low_q == 8'hff ? low_q : low_q + 8'h01);
      loaded_q <= loaded_q | REG_LOAD;
      ran_q <= ran_q | ((|run_v) & ~BUS_MODE);
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_pd_quiet: assert property (POWER_DOWN |-> run_v == 0 && true_v == 0 && comp_v == 0)
    else $error("outputs active in power-down");
  a_static_levels: assert property (!BUS_MODE && !POWER_DOWN |-> comp_v == ~run_v && true_v == 0)
    else $error("static levels wrong in strap mode");
  a_hold_length: assert property (!BUS_MODE && $rose(run_v[3]) |-> low_q >= STATIC_HOLD_CYCLES)
    else $error("bank 4 resumed before hold ended");
  a_pd_entry: assert property ($rose(PIN_IN.bus_clock_powerdown_pin) && !PIN_IN.data_line && !BUS_MODE
    |-> ##[1:4] POWER_DOWN) else $error("pin power-down not entered");
  a_pd_exit: assert property ($fell(PIN_IN.bus_clock_powerdown_pin) && POWER_DOWN && !BUS_MODE
    |-> ##[1:4] (!POWER_DOWN && run_v == 0)) else $error("pin power-down release wrong");
  a_bus_static: assert property (BUS_MODE && !ran_q && !loaded_q && !PIN_IN.mixed_control |-> run_v == 0)
    else $error("bank runs with mixed control low");
  a_load_files: assert property ((PLL_STABLE && BUS_MODE && !POWER_DOWN) [*8] ##0 REG_LOAD |=>
    REF_BYPASS == $past(REG_FILE.ref_bypass) && BLOCK_POWERDOWN == $past(REG_FILE.block_powerdown)
    && POWER_DOWN == $past(REG_FILE.powerdown)) else $error("register file not applied");
  a_load_enable: assert property ((PLL_STABLE && BUS_MODE && !POWER_DOWN) [*8] ##0 REG_LOAD
    && !REG_FILE.powerdown |=> run_v == $past(REG_FILE.output_enable & ~REG_FILE.block_powerdown))
    else $error("bank enables not applied");
endmodule

// ==== verif/cgms_board.sv ====
// Board model: strap pins, PLL lock indication and register loader.
// Assumes the bench calls its tasks; changes land on falling edges.
`timescale 1ns/1ps
module cgms_board
  import cgms_pkg::*;
#(
  parameter int LOCK_CYCLES = 12
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     power_down,
  output cgms_pins_s    pins,
  output logic          pll_stable,
  output logic          reg_load,
  output cgms_regfile_s reg_file
);
  logic [7:0] lock_q;
  // PLL loses lock in reset and power-down, relocks later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lock_q <= 8'h00;
    else if (power_down)
      lock_q <= 8'h00;
    else if (lock_q < 8'(LOCK_CYCLES))
      lock_q <= lock_q + 8'h01;
  end
  assign pll_stable = (lock_q == 8'(LOCK_CYCLES));
  initial
  begin
    pins = '0;
    reg_load = 1'b0;
    reg_file = '0;
  end
  // Data line high before reset release selects bus mode
  task automatic set_pins(input cgms_pins_s p);
    @(negedge clk);
    pins = p;
  endtask
  // Whole file in one strobe; bus shows garbage afterwards
  task automatic load(input cgms_regfile_s f);
    @(negedge clk);
    reg_file = f;
    reg_load = 1'b1;
    @(negedge clk);
    reg_load = 1'b0;
    reg_file = ~f;
  endtask
endmodule

// ==== verif/cgms_sequencer_test.sv ====
// Self-checking bench for the mode sequencer.
// Assumes the board model drives pins and loads; hold shortened to 2.
`timescale 1ns/1ps
module cgms_sequencer_test;
  import cgms_pkg::*;
  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  cgms_pins_s                 pin_in;
  cgms_pins_s                 p;
  cgms_regfile_s              reg_file;
  cgms_regfile_s              f;
  cgms_bank_s [NUM_BANKS-1:0] bank_out;
  logic                       pll_stable, reg_load, power_down, bus_mode, ref_bypass;
  logic [3:0]                 block_pd, addr_sel;
  int                         errors = 0;
  int                         samples_checked = 0;
  // Expected configs: banks 1-3 by level, bank 4 by first*3+second
  logic [5:0] t13 [3][3] = '{'{6'h27, 6'h20, 6'h22}, '{6'h27, 6'h24, 6'h25}, '{6'h27, 6'h25, 6'h22}};
  logic [5:0] t4 [9] = '{6'h01, 6'h13, 6'h16, 6'h36, 6'h27, 6'h25, 6'h20, 6'h24, 6'h38};

  always #10 core_clk = ~core_clk;

  cgms_sequencer #(.STATIC_HOLD_CYCLES(2)) i_cgms_sequencer (
    .CORE_CLK(core_clk), .RST(rst), .PIN_IN(pin_in), .PLL_STABLE(pll_stable), .REG_LOAD(reg_load),
    .REG_FILE(reg_file), .BANK_OUT(bank_out), .POWER_DOWN(power_down), .BLOCK_POWERDOWN(block_pd),
    .REF_BYPASS(ref_bypass), .BUS_MODE(bus_mode), .BUS_ADDR_SEL(addr_sel));
  cgms_board i_cgms_board (
    .clk(core_clk), .rst(rst), .power_down(power_down), .pins(pin_in), .pll_stable(pll_stable),
    .reg_load(reg_load), .reg_file(reg_file));

  function automatic logic [3:0] runs();
    for (int b = 0; b < NUM_BANKS; b++)
      runs[b] = bank_out[b].run;
  endfunction
  function automatic logic [3:0] comps();
    for (int b = 0; b < NUM_BANKS; b++)
      comps[b] = bank_out[b].bank_complement_output;
  endfunction
  function automatic cgms_pins_s pins(input logic d, m, input int l, a, s);
    pins = '{2'(l), 2'(l), 2'(l), 2'(a), 2'(s), d, 1'b0, m};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setp();
    i_cgms_board.set_pins(p);
  endtask
  // Power cycle with given straps, then wait for PLL lock
  task automatic start(input logic d, m, input int l, a, s);
    p = pins(d, m, l, a, s);
    setp();
    rst = 1'b1;
    repeat (16) @(negedge core_clk);
    chk({runs(), comps()}, 8'h0f);
    chk(8'(bank_out[3].cfg), 8'(CFG_RESET));
    rst = 1'b0;
    repeat (40) @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    start(1'b0, 1'b0, 1, 0, 1);
    chk({runs(), comps()}, 8'hf0);
    // Every bank 4 strap combination, banks 1-3 at each level; power cycle where bank 4 would change type
    for (int i = 0; i < 9; i++)
    begin
      if (i == 3)
        start(1'b0, 1'b0, 1, 1, 1);
      p = pins(1'b0, 1'b0, i % 3, i / 3, i % 3);
      setp();
      for (int n = 0; n < 8 && bank_out[3].run !== 1'b0; n++)
        @(negedge core_clk);
      chk({6'h0, bank_out[3].run, bank_out[3].bank_complement_output}, 8'h01);
      repeat (12) @(negedge core_clk);
      chk({4'h0, runs()}, 8'h0f);
      for (int b = 0; b < 3; b++)
        chk(8'(bank_out[b].cfg), 8'(t13[b][i % 3]));
      chk(8'(bank_out[3].cfg), 8'(t4[i]));
    end
    // Pin power-down and restart
    p.bus_clock_powerdown_pin = 1'b1;
    setp();
    repeat (6) @(negedge core_clk);
    chk({power_down, 3'h0, runs() | comps()}, 8'h80);
    p.bus_clock_powerdown_pin = 1'b0;
    setp();
    repeat (5) @(negedge core_clk);
    chk({power_down, 3'h0, comps()}, 8'h0f);
    chk({4'h0, runs()}, 8'h00);
    repeat (40) @(negedge core_clk);
    chk({4'h0, runs()}, 8'h0f);
    // Leave strap mode, then load register files
    p.data_line = 1'b1;
    setp();
    p.data_line = 1'b0;
    repeat (5) @(negedge core_clk);
    setp();
    repeat (5) @(negedge core_clk);
    chk({7'h0, bus_mode}, 8'h01);
    f = '0;
    f.programmed = 4'h3;
    f.output_enable = 4'hd;
    f.block_powerdown = 4'h4;
    f.ref_bypass = 1'b1;
    f.bank_cfg[0] = 6'h24;
    f.bank_cfg[1] = 6'h01;
    i_cgms_board.load(f);
    chk({4'h0, runs()}, 8'h09);
    chk(8'(bank_out[0].cfg), 8'h24);
    chk(8'(bank_out[3].cfg), 8'(t4[8]));
    chk({block_pd, 3'h0, ref_bypass}, 8'h41);
    chk({bank_out[1].bank_true_output, bank_out[1].bank_complement_output, 4'h0,
         bank_out[2].bank_true_output, bank_out[2].bank_complement_output}, 8'h01);
    f.powerdown = 1'b1;
    i_cgms_board.load(f);
    chk({7'h0, power_down}, 8'h01);
    f.powerdown = 1'b0;
    i_cgms_board.load(f);
    chk({3'h0, power_down, runs()}, 8'h00);
    repeat (40) @(negedge core_clk);
    chk({4'h0, runs()}, 8'h09);
    // Bus power-up with mixed control low
    start(1'b1, 1'b0, 1, 2, 0);
    chk({runs(), comps()}, 8'h0f);
    chk({bus_mode, ref_bypass, 2'h0, addr_sel}, 8'h88);
    p.bank4_select_first = 2'h0;
    setp();
    repeat (10) @(negedge core_clk);
    chk({runs(), comps()}, 8'h0f);
    f = '0;
    f.output_enable = 4'hf;
    i_cgms_board.load(f);
    chk({4'h0, runs()}, 8'h0f);
    for (int b = 0; b < 3; b++)
      chk(8'(bank_out[b].cfg), 8'(t13[b][1]));
    chk(8'(bank_out[3].cfg), 8'(t4[6]));
    // Mixed control high, bank 4 first select low
    start(1'b1, 1'b1, 1, 0, 1);
    chk({4'h0, runs()}, 8'h08);
    p.bank4_select_second = 2'h2;
    setp();
    repeat (10) @(negedge core_clk);
    chk(8'(bank_out[3].cfg), 8'(t4[1]));
    // Mixed control high, bank 4 first select mid
    start(1'b1, 1'b1, 2, 1, 1);
    chk({4'h0, runs()}, 8'h07);
    p = pins(1'b1, 1'b1, 0, 1, 1);
    setp();
    repeat (10) @(negedge core_clk);
    for (int b = 0; b < 3; b++)
      chk(8'(bank_out[b].cfg), 8'(t13[b][2]));
    final_report();
  end

  // Watchdog, about nine times the expected run
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    final_report();
  end
endmodule

bind cgms_sequencer cgms_sequencer_props #(.STATIC_HOLD_CYCLES(STATIC_HOLD_CYCLES)) i_cgms_sequencer_props (
  .CORE_CLK(CORE_CLK), .RST(RST), .PIN_IN(PIN_IN), .PLL_STABLE(PLL_STABLE), .REG_LOAD(REG_LOAD),
  .REG_FILE(REG_FILE), .BANK_OUT(BANK_OUT), .POWER_DOWN(POWER_DOWN), .BLOCK_POWERDOWN(BLOCK_POWERDOWN),
  .REF_BYPASS(REF_BYPASS), .BUS_MODE(BUS_MODE), .BUS_ADDR_SEL(BUS_ADDR_SEL));
